// file: cpb_consts.vh
// register map and field constants for the programmable can message buffers
`ifndef CPB_CONSTS_VH
`define CPB_CONSTS_VH
// per-buffer register window: buffer n at byte address n*0x40
`define CPB_BUF_SHIFT      6
`define CPB_NUM_BUF        6
`define CPB_REG_CON        4'h0
`define CPB_REG_IDH        4'h1
`define CPB_REG_IDL        4'h2
`define CPB_REG_EIDH       4'h3
`define CPB_REG_EIDL       4'h4
`define CPB_REG_LEN        4'h5
`define CPB_REG_DATA0      4'h8
// global registers above the buffers
`define CPB_ADDR_SEL       12'h180
`define CPB_ADDR_MODE      12'h184
// control bits in transmit mode
`define CPB_CON_DONE       7
`define CPB_CON_ABT        6
`define CPB_CON_LARB       5
`define CPB_CON_ERR        4
`define CPB_CON_REQ        3
`define CPB_CON_AUTO_REMOTE_REPLY_ENABLE      2
// identifier low byte bits
`define CPB_IDL_SRR        4
`define CPB_IDL_EXT        3
`define CPB_IDL_MASK       8'hEB
`define CPB_SEL_LSB        2
`define CPB_LEN_MASK       8'h4F
`define CPB_MODE_LEGACY    2'h0
`endif

// file: cpb_arbiter.v
// transmit arbiter: picks highest priority pending buffer, lowest index on ties
`timescale 1ns/1ps
module cpb_arbiter #(
    parameter NB = 6
) (
    // requests and priorities
    input  wire [NB-1:0]   pend,
    input  wire [2*NB-1:0] prio,
    // choice
    output reg             any,
    output reg  [2:0]      idx
);
    integer i;
    reg [1:0] best;
    // scan downward so the lowest index wins equal levels
    always @* begin
        any  = 1'b0;
        idx  = 3'h0;
        best = 2'h0;
        for (i = NB-1; i >= 0; i = i - 1) begin
            if (pend[i] && (!any || prio[2*i +: 2] >= best)) begin
                any  = 1'b1;
                idx  = i[2:0];
                best = prio[2*i +: 2];
            end
        end
    end
endmodule

// file: cpb_top.v
// six programmable can message buffers with apb register access
// How it works
// - successful send of a transmit buffer sets its done flag.
// - aborting a pending send sets the aborted flag.
// - losing arbitration while sending sets the lost-arbitration flag.
// - bus error while sending sets the bus-error flag.
// - setting the request queues the message, clears aborted, lost, error flags.
// - setting the request also clears the done flag.
// - request clears itself after a successful send.
// - software writing zero to a set request asks for an abort.
// - received remote request sets request only when auto reply enabled.
// - two-bit priority orders pending buffers, 11 highest, 00 lowest.
// - priority never changes the identifier sent on the bus.
// - buffer registers ignore writes while request set or sending.
// - buffer registers exist only in operating modes 1 and 2; the code enables them in every mode except 0, mode 3 included.
// - select bit one gives transmit layout, zero gives receive layout.
// - identifier bytes read-only in receive mode, writable in transmit mode.
// - identifier bits packed across high, low and two extended bytes.
// - received frame-type bit is one for extended frames.
// - software sets identifier-type bit to send a 29-bit identifier.
// - substitute remote request reported for received extended frames; the code sets it only for extended remote frames.
// - eight data bytes per buffer, loaded on receive, written on transmit.
// - length register holds remote bit and data length code 0 to 8; the code stores codes up to 15 and sends at most 8.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "cpb_consts.vh"
module cpb_top #(
    parameter NB = 6
) (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_r,
    output reg         pready_r,
    output reg         pslverr_r,
    // transmit engine side
    output reg         tx_start_r,
    output reg  [2:0]  tx_buf_r,
    output reg  [28:0] tx_id_r,
    output reg         tx_ext_r,
    output reg         tx_rtr_r,
    output reg  [3:0]  tx_dlc_r,
    output reg  [63:0] tx_data_r,
    output reg         tx_abort_r,
    input  wire        tx_ok,
    input  wire        tx_lost_arb,
    input  wire        tx_bus_err,
    input  wire        tx_aborted,
    // receive engine side
    input  wire        rx_load,
    input  wire [2:0]  rx_buf,
    input  wire [28:0] rx_id,
    input  wire        rx_ext,
    input  wire        rx_rtr,
    input  wire [3:0]  rx_dlc,
    input  wire [63:0] rx_data,
    input  wire        rx_rtr_hit
);
    // per-buffer storage
    reg  [7:0]    con_r  [0:NB-1];
    reg  [7:0]    idh_r  [0:NB-1];
    reg  [7:0]    idl_r  [0:NB-1];
    reg  [7:0]    eidh_r [0:NB-1];
    reg  [7:0]    eidl_r [0:NB-1];
    reg  [7:0]    len_r  [0:NB-1];
    reg  [7:0]    dat_r  [0:NB*8-1];
    reg  [NB-1:0] dir_r;       // one per buffer, 1 = transmit
    reg  [1:0]    mode_r;      // controller operating mode
    reg           busy_r;      // a frame is on the bus
    reg  [2:0]    abort_buf_r; // buffer named by the last abort write
    wire          acc  = psel && penable;
    wire          wr   = acc && pwrite;
    wire [2:0]    bsel = paddr[8:6];
    wire [3:0]    roff = paddr[5:2];
    wire          in_buf = (paddr[11:9] == 3'h0) && (bsel < NB);
    wire          bufs_on = (mode_r != `CPB_MODE_LEGACY);
    integer       k;
    integer       j;
    // pending and priority vectors for the arbiter
    reg  [NB-1:0]   pend;
    reg  [2*NB-1:0] prio;
    wire            arb_any;
    wire [2:0]      arb_idx;
    always @* begin
        pend = {NB{1'b0}};
        prio = {2*NB{1'b0}};
        for (k = 0; k < NB; k = k + 1) begin
            pend[k]       = dir_r[k] & con_r[k][`CPB_CON_REQ];
            prio[2*k +: 2] = con_r[k][1:0];
        end
    end
    cpb_arbiter #(.NB(NB)) u_arb (
        .pend (pend),
        .prio (prio),
        .any  (arb_any),
        .idx  (arb_idx)
    );
    // buffer is locked while requested or on the bus
    function locked;
        input [2:0] b;
        begin
            locked = con_r[b][`CPB_CON_REQ] || (busy_r && tx_buf_r == b);
        end
    endfunction
    // 29-bit identifier assembled from the four id bytes; a standard frame uses only the high and low bytes
    function [28:0] pack_id;
        input [7:0] h;
        input [7:0] l;
        input [7:0] eh;
        input [7:0] el;
        begin
            if (l[`CPB_IDL_EXT])
                pack_id = {h, l[7:5], l[1:0], eh, el};
            else
                pack_id = {18'h0, h, l[7:5]};
        end
    endfunction
    // read mux
    reg [7:0] rbyte;
    reg       rhit;
    always @* begin
        rbyte = 8'h00;
        rhit  = 1'b1;
        if (paddr == `CPB_ADDR_SEL)
            rbyte = {dir_r, 2'h0};
        else if (paddr == `CPB_ADDR_MODE)
            rbyte = {6'h0, mode_r};
        else if (in_buf && bufs_on) begin
            case (roff)
                `CPB_REG_CON:  rbyte = con_r[bsel];
                `CPB_REG_IDH:  rbyte = idh_r[bsel];
                `CPB_REG_IDL:  rbyte = dir_r[bsel] ? (idl_r[bsel] & `CPB_IDL_MASK) : idl_r[bsel];
                `CPB_REG_EIDH: rbyte = eidh_r[bsel];
                `CPB_REG_EIDL: rbyte = eidl_r[bsel];
                `CPB_REG_LEN:  rbyte = len_r[bsel] & `CPB_LEN_MASK;
                default: begin
                    if (roff >= `CPB_REG_DATA0)
                        rbyte = dat_r[{bsel, roff[2:0]}];
                    else
                        rhit = 1'b0;
                end
            endcase
        end else
            rhit = 1'b0;
    end
    // apb answer: one wait-free access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !rhit;
            if (psel && !penable && !pwrite)
                prdata_r <= {24'h00_0000, rbyte};
        end
    end
    // global select and mode registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r  <= {NB{1'b0}};
            mode_r <= 2'h0;
        end else if (wr && pready_r) begin
            if (paddr == `CPB_ADDR_SEL)
                dir_r <= pwdata[`CPB_SEL_LSB +: NB];
            if (paddr == `CPB_ADDR_MODE)
                mode_r <= pwdata[1:0];
        end
    end
    // transmit engine handshake
    wire start_go = arb_any && !busy_r && !tx_start_r && bufs_on;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r     <= 1'b0;
            tx_start_r <= 1'b0;
            tx_buf_r   <= 3'h0;
            tx_id_r    <= 29'h0;
            tx_ext_r   <= 1'b0;
            tx_rtr_r   <= 1'b0;
            tx_dlc_r   <= 4'h0;
            tx_data_r  <= 64'h0;
        end else begin
            tx_start_r <= start_go;
            if (start_go) begin
                busy_r   <= 1'b1;
                tx_buf_r <= arb_idx;
                // priority is not part of the identifier
                tx_id_r  <= pack_id(idh_r[arb_idx], idl_r[arb_idx],
                                    eidh_r[arb_idx], eidl_r[arb_idx]);
                tx_ext_r <= idl_r[arb_idx][`CPB_IDL_EXT];
                tx_rtr_r <= len_r[arb_idx][6];
                tx_dlc_r <= (len_r[arb_idx][3:0] > 4'h8) ? 4'h8 : len_r[arb_idx][3:0];
                for (j = 0; j < 8; j = j + 1)
                    tx_data_r[8*j +: 8] <= dat_r[{arb_idx, j[2:0]}];
            end else if (tx_ok || tx_lost_arb || tx_bus_err || tx_aborted)
                busy_r <= 1'b0;
        end
    end
    // per-buffer control, identifier and data
    wire sw_req_set = wr && pready_r && in_buf && bufs_on && roff == `CPB_REG_CON
                      && dir_r[bsel] && pwdata[`CPB_CON_REQ];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_abort_r  <= 1'b0;
            abort_buf_r <= 3'h0;
            for (k = 0; k < NB; k = k + 1) begin
                con_r[k]  <= 8'h00;
                idh_r[k]  <= 8'h00;
                idl_r[k]  <= 8'h00;
                eidh_r[k] <= 8'h00;
                eidl_r[k] <= 8'h00;
                len_r[k]  <= 8'h00;
            end
            for (k = 0; k < NB*8; k = k + 1)
                dat_r[k] <= 8'h00;
        end else begin
            tx_abort_r <= 1'b0;
            // software writes
            if (wr && pready_r && in_buf && bufs_on) begin
                if (roff == `CPB_REG_CON && dir_r[bsel]) begin
                    if (con_r[bsel][`CPB_CON_REQ]) begin
                        if (!pwdata[`CPB_CON_REQ]) begin
                            tx_abort_r  <= 1'b1;
                            abort_buf_r <= bsel;
                        end
                    end else begin
                        con_r[bsel][2:0] <= pwdata[2:0];
                        if (pwdata[`CPB_CON_REQ])
                            con_r[bsel][7:3] <= 5'h01;
                    end
                end else if (roff == `CPB_REG_CON)
                    con_r[bsel][6] <= pwdata[6];
                else if (dir_r[bsel] && !locked(bsel)) begin
                    case (roff)
                        `CPB_REG_IDH:  idh_r[bsel]  <= pwdata[7:0];
                        `CPB_REG_IDL:  idl_r[bsel]  <= pwdata[7:0] & `CPB_IDL_MASK;
                        `CPB_REG_EIDH: eidh_r[bsel] <= pwdata[7:0];
                        `CPB_REG_EIDL: eidl_r[bsel] <= pwdata[7:0];
                        `CPB_REG_LEN:  len_r[bsel]  <= pwdata[7:0] & `CPB_LEN_MASK;
                        default: begin
                            if (roff >= `CPB_REG_DATA0)
                                dat_r[{bsel, roff[2:0]}] <= pwdata[7:0];
                        end
                    endcase
                end
            end
            // transmit outcomes land after software so hardware sets win
            if (busy_r && tx_ok) begin
                con_r[tx_buf_r][`CPB_CON_DONE] <= 1'b1;
                con_r[tx_buf_r][`CPB_CON_REQ]  <= 1'b0;
            end
            if (busy_r && tx_aborted) begin
                con_r[tx_buf_r][`CPB_CON_ABT] <= 1'b1;
                con_r[tx_buf_r][`CPB_CON_REQ] <= 1'b0;
            end
            if (busy_r && tx_lost_arb)
                con_r[tx_buf_r][`CPB_CON_LARB] <= 1'b1;
            if (busy_r && tx_bus_err)
                con_r[tx_buf_r][`CPB_CON_ERR] <= 1'b1;
            // abort of a queued buffer not yet on the bus
            if (tx_abort_r && !(busy_r && tx_buf_r == abort_buf_r)) begin
                con_r[abort_buf_r][`CPB_CON_ABT] <= 1'b1;
                con_r[abort_buf_r][`CPB_CON_REQ] <= 1'b0;
            end
            // receive path and automatic remote reply
            if (rx_load && rx_buf < NB && bufs_on) begin
                if (!dir_r[rx_buf]) begin
                    idh_r[rx_buf]  <= rx_id[28:21];
                    idl_r[rx_buf]  <= {rx_id[20:18], rx_ext & rx_rtr, rx_ext, 1'b0,
                                       rx_id[17:16]};
                    eidh_r[rx_buf] <= rx_id[15:8];
                    eidl_r[rx_buf] <= rx_id[7:0];
                    len_r[rx_buf]  <= {1'b0, rx_rtr, 2'h0, rx_dlc};
                    for (j = 0; j < 8; j = j + 1)
                        dat_r[{rx_buf, j[2:0]}] <= rx_data[8*j +: 8];
                end else if (rx_rtr_hit && con_r[rx_buf][`CPB_CON_AUTO_REMOTE_REPLY_ENABLE]
                             && !con_r[rx_buf][`CPB_CON_REQ]) begin
                    con_r[rx_buf][7:3] <= 5'h01;
                end
            end
        end
    end
endmodule

// file: cpb_top_monitor.sv
// port-level assertion checker for the can message buffer block
`timescale 1ns/1ps
module cpb_top_monitor (
    // apb side
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata_r,
    input wire        pready_r,
    input wire        pslverr_r,
    // engine side
    input wire        tx_start_r,
    input wire [28:0] tx_id_r,
    input wire [3:0]  tx_dlc_r
);
    // single clock domain, reset disables all checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready_r)
        else $error("no answer one cycle after setup");
    a_ready_one_cycle: assert property (pready_r |=> !pready_r)
        else $error("ready held longer than one cycle");
    a_ready_in_access: assert property (pready_r |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_with_ready: assert property (pslverr_r |-> pready_r)
        else $error("error without ready");
    a_start_pulse: assert property (tx_start_r |=> !tx_start_r)
        else $error("start longer than one cycle");
    a_dlc_limit: assert property (tx_start_r |-> tx_dlc_r <= 4'h8)
        else $error("length code above eight");
    a_id_stands: assert property (!tx_start_r |-> $stable(tx_id_r))
        else $error("identifier changed without a start");
    a_read_low_byte: assert property (pready_r && !pwrite |-> prdata_r[31:8] == 24'h0)
        else $error("read data above low byte");
endmodule
bind cpb_top cpb_top_monitor i_cpb_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .tx_start_r(tx_start_r), .tx_id_r(tx_id_r), .tx_dlc_r(tx_dlc_r));

// file: cpb_engine_model.sv
// behavioural transmit engine standing in for the bus side
`timescale 1ns/1ps
module cpb_engine_model #(
    parameter DLY = 6
) (
    // clock and reset
    input wire       pclk,
    input wire       presetn,
    // from the buffers
    input wire       tx_start_r,
    input wire       tx_abort_r,
    // outcome: 0 ok, 1 lost, 2 error, 3 hold until abort
    input wire [1:0] outc,
    // to the buffers, and busy to the bench
    output reg       tx_ok,
    output reg       tx_lost_arb,
    output reg       tx_bus_err,
    output reg       tx_aborted,
    output reg       busy
);
    reg [7:0] cnt_r;
    // exactly one outcome pulse per frame, after a delay or as soon as an abort arrives
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tx_ok, tx_lost_arb, tx_bus_err, tx_aborted, busy} <= 5'h0;
            cnt_r <= 8'h0;
        end else begin
            {tx_ok, tx_lost_arb, tx_bus_err, tx_aborted} <= 4'h0;
            if (tx_start_r) begin
                busy  <= 1'b1;
                cnt_r <= DLY[7:0];
            end else if (busy && tx_abort_r) begin
                tx_aborted <= 1'b1;
                busy       <= 1'b0;
            end else if (busy && cnt_r != 8'h0) begin
                cnt_r <= cnt_r - 8'h1;
            end else if (busy && outc != 2'h3) begin
                tx_ok       <= (outc == 2'h0);
                tx_lost_arb <= (outc == 2'h1);
                tx_bus_err  <= (outc == 2'h2);
                busy        <= 1'b0;
            end
        end
    end
endmodule

// file: tb.sv
// self-checking bench for the can message buffer block
`timescale 1ns/1ps
`include "cpb_consts.vh"
module tb;
    reg         pclk, presetn, psel, penable, pwrite, rx_load, rx_ext, rx_rtr, rx_rtr_hit;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, seed;
    reg  [2:0]  rx_buf;
    reg  [28:0] rx_id, id;
    reg  [3:0]  rx_dlc;
    reg  [63:0] rx_data;
    reg  [1:0]  outc, p;
    reg  [7:0]  v [1:6];
    reg  [7:0]  f;
    reg  [17:0] re;
    reg  [44:0] fr, fe;
    reg  [17:0] rq [$];
    reg  [44:0] fq [$];
    wire [31:0] prdata_r;
    wire [63:0] tx_data_r;
    wire [28:0] tx_id_r;
    wire [3:0]  tx_dlc_r;
    wire [2:0]  tx_buf_r;
    wire        pready_r, pslverr_r, tx_start_r, tx_ext_r, tx_rtr_r, tx_abort_r;
    wire        tx_ok, tx_lost_arb, tx_bus_err, tx_aborted, eng_busy;
    integer     num_errors = 0, checks_done = 0, i, k;

    cpb_top i_cpb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
        .pslverr_r(pslverr_r), .tx_start_r(tx_start_r), .tx_buf_r(tx_buf_r), .tx_id_r(tx_id_r),
        .tx_ext_r(tx_ext_r), .tx_rtr_r(tx_rtr_r), .tx_dlc_r(tx_dlc_r), .tx_data_r(tx_data_r),
        .tx_abort_r(tx_abort_r), .tx_ok(tx_ok), .tx_lost_arb(tx_lost_arb), .tx_bus_err(tx_bus_err),
        .tx_aborted(tx_aborted), .rx_load(rx_load), .rx_buf(rx_buf), .rx_id(rx_id), .rx_ext(rx_ext),
        .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .rx_rtr_hit(rx_rtr_hit));
    cpb_engine_model i_cpb_engine_model (.pclk(pclk), .presetn(presetn), .tx_start_r(tx_start_r),
        .tx_abort_r(tx_abort_r), .outc(outc), .tx_ok(tx_ok), .tx_lost_arb(tx_lost_arb),
        .tx_bus_err(tx_bus_err), .tx_aborted(tx_aborted), .busy(eng_busy));

    // 100 mhz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [11:0] ba(input [2:0] b, input [3:0] r);
        ba = {3'h0, b, 6'h0} + {6'h0, r, 2'h0};
    endfunction
    task end_of_test;
        if (rq.size() + fq.size() != 0) num_errors++;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk_rd(input [8:0] g, input [8:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t read %h exp %h", $time, g, e);
        end
    endtask
    task chk_fr(input [44:0] g, input [44:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t frame %h exp %h", $time, g, e);
        end
    endtask
    // apb master: setup, access held until ready
    task apb(input w, input [11:0] a, input [7:0] d);
        integer n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_r !== 1'b1 && n++ < 50);
        {psel, penable} <= 2'b00;
    endtask
    task wr(input [11:0] a, input [7:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [11:0] a, input [8:0] m, input [8:0] e);
        rq.push_back({m, e});
        apb(1'b0, a, 8'h0);
    endtask
    task wt(input b);
        integer n;
        for (n = 0; n < 200 && eng_busy !== b; n++) @(posedge pclk);
        @(posedge pclk);
    endtask
    task rx(input [2:0] b, input h);
        @(posedge pclk);
        {rx_load, rx_buf, rx_rtr_hit} <= {1'b1, b, h};
        @(posedge pclk);
        {rx_load, rx_rtr_hit} <= 2'b00;
    endtask
    task setv(input [28:0] d, input s, input [7:0] len, input [7:0] b0);
        v[1] = d[28:21];
        v[2] = {d[20:18], s, 2'b10, d[17:16]};
        v[3] = d[15:8];
        v[4] = d[7:0];
        v[5] = len;
        v[6] = b0;
    endtask
    // answers compared against the oldest note
    always @(posedge pclk) begin
        if (pready_r && !pwrite) begin
            re = rq.pop_front();
            chk_rd({pslverr_r, prdata_r[7:0]} & re[17:9], re[8:0]);
        end
        if (tx_start_r) begin
            fe = fq.pop_front();
            chk_fr({tx_buf_r, tx_ext_r, tx_dlc_r, tx_data_r[7:0], tx_id_r}, fe);
        end
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_load, rx_buf, rx_rtr_hit} = 0;
        {rx_id, rx_ext, rx_rtr, rx_dlc, rx_data, outc, presetn} = 0;
        seed = 32'h3F8D;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CPB_ADDR_SEL, 9'h1FF, 9'h000);
        rd(ba(0, 0), 9'h100, 9'h100);
        wr(`CPB_ADDR_MODE, 8'h01);
        wr(`CPB_ADDR_SEL, 8'h0C);
        rd(`CPB_ADDR_SEL, 9'h1FF, 9'h00C);
        rd(ba(0, 0), 9'h1FF, 9'h000);
        seed = xs(seed);
        id = seed[28:0];
        p = seed[30:29];
        setv(id, 1'b0, 8'h08, seed[7:0] ^ seed[31:24]);
        for (i = 1; i < 7; i++) wr(ba(0, i < 6 ? i : 8), v[i]);
        for (i = 1; i < 7; i++) rd(ba(0, i < 6 ? i : 8), 9'h1FF, {1'b0, v[i]});
        fr = {3'h0, 1'b1, 4'h8, v[6], id};
        fq.push_back(fr);
        wr(ba(0, 0), {6'h02, p});
        wt(1'b1);
        wt(1'b0);
        rd(ba(0, 0), 9'h1FF, {1'b0, 8'h80 | {6'h0, p}});
        for (k = 1; k < 3; k++) begin
            f = (k == 1) ? 8'h20 : 8'h10;
            outc <= k[1:0];
            fq.push_back(fr);
            fq.push_back(fr);
            wr(ba(0, 0), {6'h02, p});
            rd(ba(0, 0), 9'h1FF, {1'b0, 8'h08 | {6'h0, p}});
            wr(ba(0, 1), ~v[1]);
            wt(1'b1);
            wt(1'b0);
            outc <= 2'h3;
            rd(ba(0, 0), 9'h1FF, {1'b0, 8'h08 | f | {6'h0, p}});
            wt(1'b1);
            wr(ba(0, 0), {6'h0, p});
            wt(1'b0);
            rd(ba(0, 0), 9'h1FF, {1'b0, 8'h40 | f | {6'h0, p}});
            rd(ba(0, 1), 9'h1FF, {1'b0, v[1]});
        end
        outc <= 2'h0;
        for (k = 0; k < 2; k++) begin
            wr(ba(0, 0), {5'h0, k[0], 2'h0});
            if (k == 1) fq.push_back(fr);
            rx(3'h0, 1'b1);
            wt(k[0]);
            wt(1'b0);
            rd(ba(0, 0), 9'h1FF, (k == 1) ? 9'h084 : 9'h050);
        end
        seed = xs(seed);
        {rx_id, rx_ext, rx_rtr, rx_dlc, rx_data} <= {seed[28:0], 2'b11, 4'h8, seed, seed};
        setv(seed[28:0], 1'b1, 8'h48, seed[7:0]);
        rx(3'h2, 1'b0);
        wr(ba(2, 1), ~v[1]);
        for (i = 1; i < 7; i++) rd(ba(2, i < 6 ? i : 8), 9'h1FF, {1'b0, v[i]});
        repeat (4) @(posedge pclk);
        end_of_test;
    end
endmodule
